// file: logic/fpu_ops_pkg.sv
// Constants, field layout and types for the sign/sqrt/bank datapath.
// Assumes a single 40 MHz clock and the plain register port of the top.
package fpu_ops_pkg;
  localparam int unsigned AW = 8;
  // Register offsets
  localparam logic [7:0] OFS_STATUS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EVENT       = 8'h04;
  localparam logic [7:0] OFS_MASK        = 8'h08;
  localparam logic [7:0] OFS_STATE       = 8'h0c;
  localparam int unsigned FREG_SEL_BIT   = 7;
  // Status/control field positions
  localparam int unsigned RM_LSB     = 0;
  localparam int unsigned FLAG_LSB   = 2;
  localparam int unsigned ENABLE_LSB = 7;
  localparam int unsigned CAUSE_LSB  = 12;
  localparam int unsigned DN_BIT     = 18;
  localparam int unsigned PR_BIT     = 19;
  localparam int unsigned SZ_BIT     = 20;
  localparam int unsigned FR_BIT     = 21;
  localparam logic [31:0] FPU_STATUS_CONTROL_RESET = 32'h00000000;
  localparam logic [31:0] FPU_STATUS_CONTROL_WMASK = 32'h003fffff;
  localparam logic [1:0]  RM_TOWARD_ZERO = 2'h1;
  // Exception positions inside flag, enable and cause
  localparam int unsigned EXC_I = 0;
  localparam int unsigned EXC_V = 4;
  localparam int unsigned EXC_E = 5;
  // Instruction encodings
  localparam logic [3:0]  OP_HI          = 4'hf;
  localparam logic [7:0]  OP_NEG_LO      = 8'h4d;
  localparam logic [7:0]  OP_SQRT_LO     = 8'h6d;
  localparam logic [15:0] OP_BANK_SWAP   = 16'hfbfd;
  localparam logic [15:0] OP_SIZE_TOGGLE = 16'hf3fd;
  // Execution states
  localparam logic [4:0] SQRT_STATES_SP = 5'h09;
  localparam logic [4:0] SQRT_STATES_DP = 5'h16;
  // Root extractor geometry
  localparam int unsigned ROOT_W = 54;
  localparam int unsigned RAD_W  = 108;
  localparam int unsigned STEPS_PER_CYCLE = 4;
  localparam logic [5:0] ROOT_BITS_SP = 6'h19;
  localparam logic [5:0] ROOT_BITS_DP = 6'h36;
  localparam logic [8:0]  SP_BIAS = 9'h07f;
  localparam logic [11:0] DP_BIAS = 12'h3ff;
  localparam logic [31:0] QNAN_SP = 32'h7fc00000;
  localparam logic [63:0] QNAN_DP = 64'h7ff8000000000000;
  // Event bits
  localparam int unsigned EV_TRAP  = 0;
  localparam int unsigned EV_UNDEF = 1;
  localparam int unsigned EV_DONE  = 2;
  localparam int unsigned EV_W     = 3;

  typedef enum logic [2:0] {
    CL_NORM, CL_DENORM, CL_ZERO, CL_INF, CL_QNAN, CL_SNAN
  } op_class_e;

  typedef enum logic {ST_IDLE, ST_SQRT} exec_state_e;
endpackage

// file: logic/root_extract.sv
// Iterative restoring square root of a left-aligned radicand.
// Assumes go is a one-cycle pulse and steps never exceeds ROOT_W.
`timescale 1ns/1ps
module root_extract (
  input  wire logic                           sys_clk,
  input  wire logic                           rstn,
  input  wire logic                           go,
  input  wire logic [fpu_ops_pkg::RAD_W-1:0]  radicand,
  input  wire logic [5:0]                     steps,
  output logic      [fpu_ops_pkg::ROOT_W-1:0] root,
  output logic                                rem_nonzero
);
  import fpu_ops_pkg::*;

  logic [RAD_W-1:0]  rad;
  logic [ROOT_W+3:0] rem;
  logic [5:0]        left;
  logic [RAD_W-1:0]  next_rad;
  logic [ROOT_W+3:0] next_rem;
  logic [ROOT_W-1:0] next_root;
  logic [5:0]        next_left;

  // Several bits per clock so double precision fits its state budget
  always_comb begin
    logic [ROOT_W+3:0] trial;
    trial     = '0;
    next_rad  = rad;
    next_rem  = rem;
    next_root = root;
    next_left = left;
    for (int i = 0; i < STEPS_PER_CYCLE; i++) begin
      if (next_left != 6'h00) begin
        next_rem  = {next_rem[ROOT_W+1:0], next_rad[RAD_W-1 -: 2]};
        next_rad  = {next_rad[RAD_W-3:0], 2'b00};
        trial     = {2'b00, next_root, 2'b01};
        if (next_rem >= trial) begin
          next_rem  = next_rem - trial;
          next_root = {next_root[ROOT_W-2:0], 1'b1};
        end else begin
          next_root = {next_root[ROOT_W-2:0], 1'b0};
        end
        next_left = next_left - 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rad  <= '0;
      rem  <= '0;
      root <= '0;
      left <= 6'h00;
    end else if (go) begin
      rad  <= radicand;
      rem  <= '0;
      root <= '0;
      left <= steps;
    end else begin
      rad  <= next_rad;
      rem  <= next_rem;
      root <= next_root;
      left <= next_left;
    end
  end

  assign rem_nonzero = |rem;
endmodule // root_extract

// file: logic/fpu_sign_sqrt_bank_ops.sv
// Sign negate, bank swap, size toggle and square root datapath.
// Assumes the issue logic holds instr_valid until busy is low and that
// software reaches the registers over a one-cycle read/write port.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module fpu_sign_sqrt_bank_ops (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        instr_valid,
  input  wire logic [15:0]                 instr_code,
  output logic                             busy,
  output logic                             instr_done,
  output logic                             fpu_trap,
  output logic                             undefined_op,
  input  wire logic [fpu_ops_pkg::AW-1:0]  addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [31:0]                 rdata,
  output logic                             irq,
  output logic                             bank_select_bit,
  output logic                             transfer_size_bit,
  output logic                             precision_bit
);
  import fpu_ops_pkg::*;

  logic [31:0]        freg [0:31];
  logic [31:0]        fpu_status_control;
  logic [EV_W-1:0]    event_status;
  logic [EV_W-1:0]    event_mask;
  exec_state_e        state;
  logic [4:0]         cnt;
  op_class_e          sq_cls;
  logic [63:0]        sq_val;
  logic               sq_dp;
  logic [1:0]         sq_rm;
  logic [4:0]         sq_en;
  logic [4:0]         sq_dst;
  logic               sq_go;
  logic [RAD_W-1:0]   sq_rad;
  logic [ROOT_W-1:0]  root;
  logic               rem_nonzero;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic [4:0] phys_idx(input logic fr,
                                          input logic [3:0] idx);
    phys_idx = {fr, idx};
  endfunction

  function automatic op_class_e classify(input logic [63:0] v,
                                         input logic dp,
                                         input logic dn);
    logic emax;
    logic ezero;
    logic fzero;
    logic quiet;
    emax  = dp ? &v[62:52] : &v[62:55];
    ezero = dp ? ~|v[62:52] : ~|v[62:55];
    fzero = dp ? ~|v[51:0] : ~|v[54:32];
    quiet = dp ? v[51] : v[54];
    if (emax)
      classify = fzero ? CL_INF : (quiet ? CL_QNAN : CL_SNAN);
    else if (ezero)
      classify = (fzero || dn) ? CL_ZERO : CL_DENORM;
    else
      classify = CL_NORM;
  endfunction

  logic        pr;
  logic        fr;
  logic        accept;
  logic        is_neg;
  logic        is_sqrt;
  logic        is_swap;
  logic        is_size;
  logic [3:0]  n_sel;
  logic [4:0]  dst;
  logic [63:0] operand;
  logic        finish;

  assign pr      = fpu_status_control[PR_BIT];
  assign fr      = fpu_status_control[FR_BIT];
  assign accept  = instr_valid && !busy;
  assign is_neg  = instr_code[15:12] == OP_HI
                   && instr_code[7:0] == OP_NEG_LO;
  assign is_sqrt = instr_code[15:12] == OP_HI
                   && instr_code[7:0] == OP_SQRT_LO;
  assign is_swap = instr_code == OP_BANK_SWAP;
  assign is_size = instr_code == OP_SIZE_TOGGLE;
  // Double forms address the even register of a pair
  assign n_sel   = pr ? {instr_code[11:9], 1'b0} : instr_code[11:8];
  assign dst     = phys_idx(fr, n_sel);
  assign operand = pr ? {freg[dst], freg[{dst[4:1], 1'b1}]}
                      : {freg[dst], 32'h0};
  assign finish  = state == ST_SQRT && cnt == 5'h00;

  ////////////////////////////////////////////////////////////////////////
  // Square root sequencing

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt   <= 5'h00;
    end else if (accept && is_sqrt) begin
      state <= ST_SQRT;
      // Root starts on the take edge; done follows the last count
      cnt   <= (pr ? SQRT_STATES_DP : SQRT_STATES_SP) - 5'h02;
    end else if (finish) begin
      state <= ST_IDLE;
    end else if (state == ST_SQRT) begin
      cnt   <= cnt - 5'h01;
    end
  end

  // Operand and mode are frozen at issue; later writes cannot disturb it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sq_cls <= CL_ZERO;
      sq_val <= '0;
      sq_dp  <= 1'b0;
      sq_rm  <= 2'h0;
      sq_en  <= 5'h00;
      sq_dst <= 5'h00;
    end else if (accept && is_sqrt) begin
      sq_cls <= classify(operand, pr, fpu_status_control[DN_BIT]);
      sq_val <= operand;
      sq_dp  <= pr;
      sq_rm  <= fpu_status_control[RM_LSB +: 2];
      sq_en  <= fpu_status_control[ENABLE_LSB +: 5];
      sq_dst <= dst;
    end
  end

  // Radicand is formed straight from the operand so the root loads on
  // the take edge and fits the state budget.
  // Odd unbiased exponent doubles the radicand
  assign sq_go  = accept && is_sqrt;
  assign sq_rad = pr ? {2'b01, operand[51:0], 54'h0} << !operand[52]
                     : {2'b01, operand[54:32], 83'h0} << !operand[55];

  root_extract u_root (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .go          (sq_go),
    .radicand    (sq_rad),
    .steps       (pr ? ROOT_BITS_DP : ROOT_BITS_SP),
    .root        (root),
    .rem_nonzero (rem_nonzero)
  );

  ////////////////////////////////////////////////////////////////////////
  // Result, rounding and exceptions

  logic [5:0]  exc;
  logic        norm_ok;
  logic        trap_now;
  logic        wb;
  logic [63:0] res;
  logic        sq_gt;
  logic [8:0]  sp_sum;
  logic [11:0] dp_sum;
  logic [23:0] sp_mant;
  logic [52:0] dp_mant;

  // The root's guard bit tells whether rounding went up, i.e. whether
  // the squared rounded root exceeds the operand; square roots never tie.
  assign sq_gt  = root[0];
  assign sp_sum = {1'b0, sq_val[62:55]} + SP_BIAS;
  assign dp_sum = {1'b0, sq_val[62:52]} + DP_BIAS;

  always_comb begin
    sp_mant = root[24:1] + {23'h0, root[0]};
    dp_mant = root[53:1] + {52'h0, root[0]};
    if (sq_rm == RM_TOWARD_ZERO && sq_gt) begin
      sp_mant = sp_mant - 24'h1;
      // One wide subtract: the borrow runs into the upper word
      dp_mant = dp_mant - 53'h1;
    end
  end

  always_comb begin
    exc     = 6'h00;
    res     = sq_val;
    norm_ok = 1'b0;
    unique case (sq_cls)
      CL_NORM: begin
        if (sq_val[63]) begin
          exc[EXC_V] = 1'b1;
        end else begin
          norm_ok    = 1'b1;
          exc[EXC_I] = sq_gt || rem_nonzero;
          res = sq_dp ? {1'b0, dp_sum[11:1], dp_mant[51:0]}
                      : {1'b0, sp_sum[8:1], sp_mant[22:0], 32'h0};
        end
      end
      CL_DENORM: begin
        if (sq_val[63])
          exc[EXC_V] = 1'b1;
        else
          exc[EXC_E] = 1'b1;
      end
      CL_INF: begin
        exc[EXC_V] = sq_val[63];
      end
      CL_SNAN: begin
        exc[EXC_V] = 1'b1;
      end
      CL_ZERO, CL_QNAN: begin
        exc = 6'h00;
      end
    endcase
    if (exc[EXC_V])
      res = sq_dp ? QNAN_DP : {QNAN_SP, 32'h0};
    trap_now = exc[EXC_E] || (exc[EXC_V] && sq_en[EXC_V])
               || (norm_ok && sq_en[EXC_I]);
    wb = !trap_now && (norm_ok || exc[EXC_V]);
  end

  ////////////////////////////////////////////////////////////////////////
  // Status/control register

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fpu_status_control <= FPU_STATUS_CONTROL_RESET;
    end else if (accept && is_sqrt) begin
      fpu_status_control[CAUSE_LSB +: 6] <= 6'h00;
    end else if (finish) begin
      fpu_status_control[CAUSE_LSB +: 6] <= exc;
      fpu_status_control[FLAG_LSB +: 5] <=
        fpu_status_control[FLAG_LSB +: 5] | exc[4:0];
    end else if (accept && is_swap && !pr) begin
      fpu_status_control[FR_BIT] <= !fr;
    end else if (accept && is_size && !pr) begin
      fpu_status_control[SZ_BIT] <= !fpu_status_control[SZ_BIT];
    end else if (wr && addr == OFS_STATUS_CTRL) begin
      fpu_status_control <= wdata & FPU_STATUS_CONTROL_WMASK;
    end
  end

  // Move logic outside reads this to choose single or paired transfers
  assign transfer_size_bit = fpu_status_control[SZ_BIT];
  assign bank_select_bit   = fpu_status_control[FR_BIT];
  assign precision_bit     = fpu_status_control[PR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++)
        freg[i] <= 32'h0;
    end else if (accept && is_neg) begin
      // Double sign lives in the even register of the pair
      freg[dst][31] <= !freg[dst][31];
    end else if (finish && wb) begin
      freg[sq_dst] <= res[63:32];
      if (sq_dp)
        freg[{sq_dst[4:1], 1'b1}] <= res[31:0];
    end else if (wr && addr[FREG_SEL_BIT]) begin
      freg[addr[6:2]] <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Handshake to issue and exception logic

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy         <= 1'b0;
      instr_done   <= 1'b0;
      fpu_trap     <= 1'b0;
      undefined_op <= 1'b0;
    end else begin
      busy         <= (accept && is_sqrt) || (state == ST_SQRT && !finish);
      instr_done   <= finish || (accept && !is_sqrt
                     && (is_neg || ((is_swap || is_size) && !pr)));
      fpu_trap     <= finish && trap_now;
      undefined_op <= accept && (is_swap || is_size) && pr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  assign ev_set = {finish, accept && (is_swap || is_size) && pr,
                   finish && trap_now};
  assign ev_clr = (wr && addr == OFS_EVENT) ? wdata[EV_W-1:0] : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      event_status <= '0;
      event_mask   <= '0;
      irq          <= 1'b0;
    end else begin
      event_status <= (event_status & ~ev_clr) | ev_set;
      if (wr && addr == OFS_MASK)
        event_mask <= wdata[EV_W-1:0];
      irq <= |(event_status & event_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0;
    end else if (!rd) begin
      rdata <= 32'h0;
    end else if (addr[FREG_SEL_BIT]) begin
      rdata <= freg[addr[6:2]];
    end else begin
      unique case (addr)
        OFS_STATUS_CTRL: rdata <= fpu_status_control;
        OFS_EVENT:       rdata <= {29'h0, event_status};
        OFS_MASK:        rdata <= {29'h0, event_mask};
        OFS_STATE:       rdata <= {26'h0, busy, cnt};
        default:         rdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic neg_acc;
  logic sqrt_acc;
  assign neg_acc  = accept && is_neg;
  assign sqrt_acc = accept && is_sqrt;

  sequence s_sp_run;
    !instr_done [*8] ##1 instr_done;
  endsequence

  property p_neg_state;
    neg_acc |=> instr_done && freg[$past(dst)][31] != $past(freg[dst][31]);
  endproperty
  a_neg_state: assert property (p_neg_state)
    else $error("negate did not flip sign in one state");

  property p_neg_quiet;
    neg_acc |=> !fpu_trap && fpu_status_control[17:2]
      == $past(fpu_status_control[17:2]);
  endproperty
  a_neg_quiet: assert property (p_neg_quiet)
    else $error("negate touched cause, flags or trapped");

  property p_swap;
    accept && is_swap && !pr |=> bank_select_bit != $past(bank_select_bit);
  endproperty
  a_swap: assert property (p_swap)
    else $error("bank swap did not toggle bit 21");

  property p_swap_undef;
    accept && is_swap && pr |=> undefined_op
      && bank_select_bit == $past(bank_select_bit);
  endproperty
  a_swap_undef: assert property (p_swap_undef)
    else $error("double bank swap not undefined");

  property p_size;
    accept && is_size && !pr |=> instr_done
      && transfer_size_bit != $past(transfer_size_bit);
  endproperty
  a_size: assert property (p_size)
    else $error("size toggle did not invert");

  property p_sqrt_sp;
    sqrt_acc && !pr |=> s_sp_run;
  endproperty
  a_sqrt_sp: assert property (p_sqrt_sp)
    else $error("single root not done after 9 states");

  property p_sqrt_dp;
    sqrt_acc && pr |-> ##22 instr_done;
  endproperty
  a_sqrt_dp: assert property (p_sqrt_dp)
    else $error("double root not done after 22 states");

  property p_cause_clear;
    sqrt_acc |=> fpu_status_control[CAUSE_LSB +: 6] == 6'h00;
  endproperty
  a_cause_clear: assert property (p_cause_clear)
    else $error("cause not cleared at root start");

  property p_inexact_trap;
    finish && sq_cls == CL_NORM && !sq_val[63] && sq_en[EXC_I]
      |=> fpu_trap && instr_done;
  endproperty
  a_inexact_trap: assert property (p_inexact_trap)
    else $error("inexact enable did not force a trap");

  property p_trap_pulse;
    fpu_trap |-> !$past(wb) ##1 !fpu_trap;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse)
    else $error("trap not single cycle or write not suppressed");
endmodule // fpu_sign_sqrt_bank_ops

// file: verif/issue_model.sv
// Issue logic stand-in: presents one decoded instruction at a time.
// Assumes the bench pulses req for one cycle and waits for completion.
`timescale 1ns/1ps
module issue_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        req,
  input  wire logic [15:0] req_code,
  input  wire logic        busy,
  output logic             instr_valid,
  output logic [15:0]      instr_code,
  output logic             taken
);
  // Released code is inverted so a stale sample cannot match
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      instr_valid <= 1'b0;
      instr_code  <= 16'h0;
      taken       <= 1'b0;
    end else begin
      taken <= instr_valid && !busy;
      if (req) begin
        instr_valid <= 1'b1;
        instr_code  <= req_code;
      end else if (instr_valid && !busy) begin
        instr_valid <= 1'b0;
        instr_code  <= ~instr_code;
      end
    end
  end
endmodule // issue_model

// file: verif/tb_fpu_sign_sqrt_bank_ops.sv
// Self-checking bench: square root table, then negate, toggles, irq.
// Assumes the register port answers one cycle after each read strobe.
`timescale 1ns/1ps
module tb_fpu_sign_sqrt_bank_ops;
  import fpu_ops_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl, hi, lo, rhi, rlo;
    logic        trap;
    logic [5:0]  cause;
  } row_s;
  localparam logic [31:0] F = 32'h0bad0bad;
  logic          sys_clk, rstn, req, wr, rd, instr_valid, taken, busy;
  logic          instr_done, fpu_trap, undefined_op, irq, precision_bit;
  logic          bank_select_bit, transfer_size_bit;
  logic          busy_s, trap_s, undef_s, done_s;
  logic [15:0]   req_code, instr_code;
  logic [AW-1:0] addr;
  logic [31:0]   wdata, rdata, d, n;
  logic [15:0]   tgl[2] = '{16'hfbfd, 16'hf3fd};
  logic [31:0]   togs[4] = '{32'h200000, 32'h300000, 32'h100000, 32'h0};
  int            err_count, check_count;
  row_s          rows[19];

  issue_model i_issue (.sys_clk(sys_clk), .rstn(rstn), .req(req),
    .req_code(req_code), .busy(busy), .instr_valid(instr_valid),
    .instr_code(instr_code), .taken(taken));

  fpu_sign_sqrt_bank_ops i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .instr_valid(instr_valid), .instr_code(instr_code), .busy(busy),
    .instr_done(instr_done), .fpu_trap(fpu_trap),
    .undefined_op(undefined_op), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .bank_select_bit(bank_select_bit),
    .transfer_size_bit(transfer_size_bit), .precision_bit(precision_bit));

////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Counts edges from the take edge until done or undefined shows
  task automatic run_op(input logic [15:0] c);
    @(posedge sys_clk);
    req      <= 1'b1;
    req_code <= c;
    @(posedge sys_clk);
    req <= 1'b0;
    n = 0;
    done_s = 1'b0;
    undef_s = 1'b0;
    while (!done_s && !undef_s && n < 40) begin
      @(posedge sys_clk);
      #1 n++;
      if (n == 1) busy_s = busy;
      if (n == 1) chk_bit("taken", 1'b1, taken);
      done_s = instr_done;
      trap_s = fpu_trap;
      undef_s = undefined_op;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // About 560 cycles expected; 5000 cycles means a hang
  initial begin
    #125000;
    err_count++;
    stop_test();
  end

  initial begin
    rstn = 1'b0;
    req = 1'b0;
    req_code = 16'h0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    err_count = 0;
    check_count = 0;
    rows = '{
      '{32'h0, 32'h40800000, F, 32'h40000000, F, 1'h0, 6'h00},
      '{32'h0, 32'hc0800000, F, 32'h7fc00000, F, 1'h0, 6'h10},
      '{32'h800, 32'hc0800000, F, 32'hc0800000, F, 1'h1, 6'h10},
      '{32'h0, 32'h00000000, F, 32'h00000000, F, 1'h0, 6'h00},
      '{32'h0, 32'h80000000, F, 32'h80000000, F, 1'h0, 6'h00},
      '{32'h0, 32'h7f800000, F, 32'h7f800000, F, 1'h0, 6'h00},
      '{32'h0, 32'hff800000, F, 32'h7fc00000, F, 1'h0, 6'h10},
      '{32'h0, 32'h7f800001, F, 32'h7fc00000, F, 1'h0, 6'h10},
      '{32'h0, 32'h7fc00001, F, 32'h7fc00001, F, 1'h0, 6'h00},
      '{32'h0, 32'h00000001, F, 32'h00000001, F, 1'h1, 6'h20},
      '{32'h0, 32'h80000001, F, 32'h7fc00000, F, 1'h0, 6'h10},
      '{32'h40000, 32'h80000001, F, 32'h80000001, F, 1'h0, 6'h00},
      '{32'h0, 32'h40000000, F, 32'h3fb504f3, F, 1'h0, 6'h01},
      '{32'h0, 32'h40a00000, F, 32'h400f1bbd, F, 1'h0, 6'h01},
      '{32'h1, 32'h40a00000, F, 32'h400f1bbc, F, 1'h0, 6'h01},
      '{32'h80, 32'h40800000, F, 32'h40800000, F, 1'h1, 6'h00},
      '{32'h80000, 32'h40100000, 32'h0, 32'h40000000, 32'h0, 1'h0, 6'h00},
      '{32'h80000, 32'h40000000, 32'h0, 32'h3ff6a09e, 32'h667f3bcd, 1'h0,
        6'h01},
      '{32'h80000, 32'hfff00000, 32'h0, 32'h7ff80000, 32'h0, 1'h0, 6'h10}};
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    #1 chk_bit("busy", 1'b0, busy);
    chk_bit("bank", 1'b0, bank_select_bit);
    rd_reg(OFS_STATUS_CTRL);
    chk_word("ctrl", 32'h0, d);
    wr_reg(8'h40, 32'hffffffff);
    rd_reg(8'h40);
    chk_word("unmapped", 32'h0, d);
    foreach (rows[i]) begin
      // Stale cause bits are written in so the clearing shows
      wr_reg(OFS_STATUS_CTRL, rows[i].ctrl | 32'h3f000);
      wr_reg(8'h88, rows[i].hi);
      wr_reg(8'h8c, rows[i].lo);
      run_op(16'hf26d);
      chk_word("states", rows[i].ctrl[19] ? 32'h16 : 32'h9, n);
      chk_bit("busy", 1'b1, busy_s);
      chk_bit("trap", rows[i].trap, trap_s);
      rd_reg(8'h88);
      chk_word("hi", rows[i].rhi, d);
      rd_reg(8'h8c);
      chk_word("lo", rows[i].rlo, d);
      rd_reg(OFS_STATUS_CTRL);
      chk_word("cause", {26'h0, rows[i].cause}, {26'h0, d[17:12]});
    end
    wr_reg(OFS_STATUS_CTRL, 32'h3f07c);
    wr_reg(8'h88, 32'h3f800000);
    wr_reg(8'h8c, F);
    run_op(16'hf24d);
    chk_word("states", 32'h1, n);
    chk_bit("trap", 1'b0, trap_s);
    rd_reg(8'h88);
    chk_word("neg", 32'hbf800000, d);
    rd_reg(OFS_STATUS_CTRL);
    chk_word("ctrl", 32'h3f07c, d);
    wr_reg(OFS_STATUS_CTRL, 32'h80000);
    run_op(16'hf24d);
    chk_bit("prec", 1'b1, precision_bit);
    rd_reg(8'h88);
    chk_word("neg", 32'h3f800000, d);
    rd_reg(8'h8c);
    chk_word("lo", F, d);
    wr_reg(OFS_STATUS_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      run_op(tgl[i%2]);
      chk_word("states", 32'h1, n);
      rd_reg(OFS_STATUS_CTRL);
      chk_word("ctrl", togs[i], d);
      if (i == 1) begin
        chk_bit("size", 1'b1, transfer_size_bit);
        chk_bit("bank", 1'b1, bank_select_bit);
        wr_reg(8'hc8, 32'h40000000);
        run_op(16'hf24d);
        rd_reg(8'hc8);
        chk_word("bank1", 32'hc0000000, d);
        rd_reg(8'h88);
        chk_word("bank0", 32'h3f800000, d);
      end
    end
    wr_reg(OFS_EVENT, 32'h7);
    wr_reg(OFS_STATUS_CTRL, 32'h80000);
    for (int i = 0; i < 2; i++) begin
      run_op(tgl[i]);
      chk_bit("undef", 1'b1, undef_s);
      chk_bit("done", 1'b0, done_s);
    end
    rd_reg(OFS_STATUS_CTRL);
    chk_word("ctrl", 32'h80000, d);
    rd_reg(OFS_EVENT);
    chk_word("event", 32'h2, d);
    chk_bit("irq", 1'b0, irq);
    wr_reg(OFS_MASK, 32'h2);
    repeat (2) @(posedge sys_clk);
    #1 chk_bit("irq", 1'b1, irq);
    wr_reg(OFS_EVENT, 32'h2);
    repeat (2) @(posedge sys_clk);
    #1 chk_bit("irq", 1'b0, irq);
    stop_test();
  end
endmodule // tb_fpu_sign_sqrt_bank_ops
